// ### adsc_defines.vh
// Register map, field positions, reset values and timing counts for the converter control
`ifndef ADSC_DEFINES_VH
`define ADSC_DEFINES_VH

// Register byte addresses
`define ADSC_CTRL0_ADDR     5'h00
`define ADSC_CTRL1_ADDR     5'h04
`define ADSC_BGAP_ADDR      5'h08
`define ADSC_RESH_ADDR      5'h0C
`define ADSC_RESL_ADDR      5'h10
`define ADSC_ADDR_W         5

// First control register fields
`define ADSC_C0_START       7
`define ADSC_C0_BUSY        6
`define ADSC_C0_PWR         5
`define ADSC_C0_ALIGN       4
`define ADSC_C0_GAIN_LO     3
`define ADSC_C0_CHAN_HI     2
`define ADSC_C0_CHAN_LO     0

// Second control register fields
`define ADSC_C1_SRC_HI      7
`define ADSC_C1_SRC_LO      6
`define ADSC_C1_GAIN_HI     5
`define ADSC_C1_REF_HI      4
`define ADSC_C1_REF_LO      3
`define ADSC_C1_DIV_HI      2
`define ADSC_C1_DIV_LO      0

// Bandgap control field
`define ADSC_BG_EN          3

// Reset values
`define ADSC_CTRL0_RST      8'h00
`define ADSC_CTRL1_RST      8'h00
`define ADSC_BGAP_RST       1'h0

// Conversion timing in conversion clock periods
`define ADSC_SAMPLE_CLKS    4'h4
`define ADSC_CONVERT_CLKS   4'hA

// AXI responses
`define ADSC_RESP_OKAY      2'h0
`define ADSC_RESP_SLVERR    2'h2

`endif

// ### adsc_clk_div.v
// Conversion clock divider: one-cycle tick at fsys / 2^sel
`timescale 1ns/10ps
`default_nettype none

module adsc_clk_div (
  // Clock and reset
  input  wire       clk,
  input  wire       sys_rst,
  // Control
  input  wire       run,
  input  wire [2:0] div_sel,
  // Tick out
  output reg        tick_r
);

  reg  [6:0] cnt_r;   // Free counter while running
  wire [6:0] mask;    // Low bits that must be all ones

  // Mask of 2^sel - 1
  assign mask = (7'h7F >> (3'h7 - div_sel));

  // Divide by power of two
  always @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      cnt_r  <= 7'h00;
      tick_r <= 1'b0;
    end else if (!run) begin
      // Restart phase for each conversion
      cnt_r  <= 7'h00;
      tick_r <= 1'b0;
    end else begin
      cnt_r  <= cnt_r + 7'h01;
      tick_r <= ((cnt_r & mask) == mask);
    end
  end

endmodule // adsc_clk_div

`default_nettype wire

// ### adsc_top.v
// AXI4-Lite converter sequencing control: sources, reference, divider, start/busy
// Functional notes
// (RULE1) Source code 00 routes external pin channel
// (RULE2) Software guards channel before internal source
// (RULE3) Channel codes 100-111 connect no pin
// (RULE4) Reference: 00/11 pin, 01 supply, 10 amp
// (RULE5) Software avoids reference pin with internal ref
// (RULE6) Conversion clock is fsys over 2^code
// (RULE7) Second register bit5 is gain high bit
// (RULE8) Bandgap on if enable bit or LOW_VOLTAGE_RESET
// (RULE9) Bandgap register unused bits read zero
// (RULE10) Start on high then low write
// (RULE11) Busy set when conversion starts
// (RULE12) Done clears busy, sets request flag
// (RULE13) Software keeps conversion clock 0.5-10 us
// (RULE14) Software waits power-up before starting
// (RULE15) Software disables converter when idle
// (RULE16) Second register read-write, resets zero
// (RULE17) Conversion is 4 sample, 10 convert
// (RULE18) Alignment bit formats result bytes
// (RULE19) Results held while power disabled
// (RULE20) Falling start edge; ignored while busy
`timescale 1ns/10ps
`default_nettype none
`include "adsc_defines.vh"

module adsc_top (
  // Clock and reset
  input  wire        clk,
  input  wire        sys_rst,
  // AXI4-Lite write address
  input  wire [31:0] s_axi_awaddr,
  input  wire        s_axi_awvalid,
  output reg         s_axi_awready,
  // AXI4-Lite write data
  input  wire [31:0] s_axi_wdata,
  input  wire [3:0]  s_axi_wstrb,
  input  wire        s_axi_wvalid,
  output reg         s_axi_wready,
  // AXI4-Lite write response
  output reg  [1:0]  s_axi_bresp,
  output reg         s_axi_bvalid,
  input  wire        s_axi_bready,
  // AXI4-Lite read address
  input  wire [31:0] s_axi_araddr,
  input  wire        s_axi_arvalid,
  output reg         s_axi_arready,
  // AXI4-Lite read data
  output reg  [31:0] s_axi_rdata,
  output reg  [1:0]  s_axi_rresp,
  output reg         s_axi_rvalid,
  input  wire        s_axi_rready,
  // Converter core side
  input  wire [9:0]  core_result,
  input  wire        lvr_enable,
  output reg  [3:0]  ext_pin_connect_r,
  output reg  [3:0]  input_route_r,
  output reg  [2:0]  ref_route_r,
  output reg  [1:0]  amp_gain_sel_r,
  output reg         conv_power_r,
  output reg         bandgap_on_r,
  output reg         sample_phase_r,
  output reg         convert_phase_r,
  output reg         conv_done_r,
  output reg         conv_irq_flag_r
);

  // Converter state, one-hot
  localparam [2:0] ST_IDLE   = 3'b001;
  localparam [2:0] ST_SAMPLE = 3'b010;
  localparam [2:0] ST_CONV   = 3'b100;

  reg  [7:0]  ctrl0_r;        // First control register (busy bit unused)
  reg  [7:0]  ctrl1_r;        // Second control register
  reg         bg_en_r;        // Bandgap enable bit
  reg  [9:0]  result_r;       // Latched conversion result
  reg  [2:0]  state_r;        // Sequencer state
  reg  [3:0]  phase_cnt_r;    // Conversion clock periods in phase
  reg         start_armed_r;  // Start bit seen high
  reg         busy_r;         // Conversion in progress
  reg  [4:0]  wr_addr_r;      // Captured write address
  reg  [31:0] wr_data_r;      // Captured write data
  reg  [3:0]  wr_strb_r;      // Captured write strobes
  reg         aw_have_r;      // Write address held
  reg         w_have_r;       // Write data held
  wire        div_tick;       // One conversion clock period elapsed
  wire        do_write;       // Both halves of write present
  wire        wr_start_bit;   // Start bit in this write
  wire        start_evt;      // Accepted start event
  wire        phase_last;     // Final period of a phase
  reg  [31:0] rd_mux;         // Read data selection
  reg         rd_ok;          // Read address mapped
  wire [4:0]  rd_addr;        // Read word address

  // Conversion clock generation
  // (RULE6) Power-of-two divider
  adsc_clk_div u_div (
    .clk     (clk),
    .sys_rst (sys_rst),
    .run     (busy_r),
    .div_sel (ctrl1_r[`ADSC_C1_DIV_HI:`ADSC_C1_DIV_LO]),
    .tick_r  (div_tick)
  );

  // Write happens when address and data are both held
  assign do_write     = aw_have_r && w_have_r && !s_axi_bvalid;
  assign wr_start_bit = wr_data_r[`ADSC_C0_START];
  // (RULE10) High then low
  // (RULE20) Ignored while busy
  assign start_evt    = do_write && (wr_addr_r == `ADSC_CTRL0_ADDR) && wr_strb_r[0]
                        && start_armed_r && !wr_start_bit && !busy_r
                        && ctrl0_r[`ADSC_C0_PWR];
  assign phase_last   = div_tick && (phase_cnt_r == 4'h1);

  // Write channel capture and response
  always @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      s_axi_awready <= 1'b1;
      s_axi_wready  <= 1'b1;
      s_axi_bvalid  <= 1'b0;
      s_axi_bresp   <= `ADSC_RESP_OKAY;
      aw_have_r     <= 1'b0;
      w_have_r      <= 1'b0;
      wr_addr_r     <= 5'h00;
      wr_data_r     <= 32'h00000000;
      wr_strb_r     <= 4'h0;
    end else begin
      // Address taken in any order
      if (s_axi_awvalid && s_axi_awready) begin
        wr_addr_r     <= {s_axi_awaddr[4:2], 2'b00};
        aw_have_r     <= 1'b1;
        s_axi_awready <= 1'b0;
      end
      // Data taken in any order
      if (s_axi_wvalid && s_axi_wready) begin
        wr_data_r    <= s_axi_wdata;
        wr_strb_r    <= s_axi_wstrb;
        w_have_r     <= 1'b1;
        s_axi_wready <= 1'b0;
      end
      // Both present: commit and answer
      if (do_write) begin
        s_axi_bvalid <= 1'b1;
        s_axi_bresp  <= (wr_addr_r <= `ADSC_RESL_ADDR) ? `ADSC_RESP_OKAY : `ADSC_RESP_SLVERR;
        aw_have_r    <= 1'b0;
        w_have_r     <= 1'b0;
      end
      // Response accepted, reopen channels
      if (s_axi_bvalid && s_axi_bready) begin
        s_axi_bvalid  <= 1'b0;
        s_axi_awready <= 1'b1;
        s_axi_wready  <= 1'b1;
      end
    end
  end

  // Register writes
  always @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      ctrl0_r       <= `ADSC_CTRL0_RST;
      // (RULE16) Resets to zero
      ctrl1_r       <= `ADSC_CTRL1_RST;
      bg_en_r       <= `ADSC_BGAP_RST;
      start_armed_r <= 1'b0;
    end else if (do_write && wr_strb_r[0]) begin
      case (wr_addr_r)
        `ADSC_CTRL0_ADDR: begin
          // Busy bit is read-only, not stored
          ctrl0_r <= {wr_data_r[7], 1'b0, wr_data_r[5:0]};
          // (RULE20) Arm on high value
          start_armed_r <= wr_start_bit;
        end
        // (RULE16) Fully writable
        `ADSC_CTRL1_ADDR: ctrl1_r <= wr_data_r[7:0];
        `ADSC_BGAP_ADDR:  bg_en_r <= wr_data_r[`ADSC_BG_EN];
        default: ;
      endcase
    end
  end

  // Conversion sequencer
  always @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      state_r         <= ST_IDLE;
      busy_r          <= 1'b0;
      phase_cnt_r     <= 4'h0;
      result_r        <= 10'h000;
      conv_done_r     <= 1'b0;
      conv_irq_flag_r <= 1'b0;
      sample_phase_r  <= 1'b0;
      convert_phase_r <= 1'b0;
    end else begin
      conv_done_r <= 1'b0;
      case (state_r)
        ST_IDLE: begin
          if (start_evt) begin
            // (RULE11) Busy on start
            busy_r         <= 1'b1;
            // (RULE17) Sampling periods
            phase_cnt_r    <= `ADSC_SAMPLE_CLKS;
            sample_phase_r <= 1'b1;
            state_r        <= ST_SAMPLE;
          end
        end
        ST_SAMPLE: begin
          if (phase_last) begin
            // (RULE17) Conversion periods
            phase_cnt_r     <= `ADSC_CONVERT_CLKS;
            sample_phase_r  <= 1'b0;
            convert_phase_r <= 1'b1;
            state_r         <= ST_CONV;
          end else if (div_tick) begin
            phase_cnt_r <= phase_cnt_r - 4'h1;
          end
        end
        ST_CONV: begin
          if (phase_last) begin
            // (RULE12) Clear busy, raise flag
            busy_r          <= 1'b0;
            conv_done_r     <= 1'b1;
            conv_irq_flag_r <= 1'b1;
            convert_phase_r <= 1'b0;
            state_r         <= ST_IDLE;
            // (RULE19) Hold result when unpowered
            if (ctrl0_r[`ADSC_C0_PWR]) begin
              result_r <= core_result;
            end
          end else if (div_tick) begin
            phase_cnt_r <= phase_cnt_r - 4'h1;
          end
        end
        default: begin
          state_r <= ST_IDLE;
          busy_r  <= 1'b0;
        end
      endcase
      // Flag cleared by a new start; completion above sets it
      if (start_evt) begin
        conv_irq_flag_r <= 1'b0;
      end
    end
  end

  // Analog routing and enables, registered
  always @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      ext_pin_connect_r <= 4'h0;
      input_route_r     <= 4'h0;
      ref_route_r       <= 3'h0;
      amp_gain_sel_r    <= 2'h0;
      conv_power_r      <= 1'b0;
      bandgap_on_r      <= 1'b0;
    end else begin
      // (RULE1) External only with source 00
      // (RULE3) Codes 100-111 connect nothing
      ext_pin_connect_r <= (ctrl1_r[7:6] == 2'b00 && !ctrl0_r[2])
                           ? (4'h1 << ctrl0_r[1:0]) : 4'h0;
      // One-hot: ext, amp output, battery/4, supply/4
      input_route_r     <= 4'h1 << ctrl1_r[7:6];
      // (RULE4) Pin, supply, amp reference
      case (ctrl1_r[`ADSC_C1_REF_HI:`ADSC_C1_REF_LO])
        2'b01:   ref_route_r <= 3'h2;
        2'b10:   ref_route_r <= 3'h4;
        default: ref_route_r <= 3'h1;
      endcase
      // (RULE7) Gain bits from two registers
      amp_gain_sel_r    <= {ctrl1_r[`ADSC_C1_GAIN_HI], ctrl0_r[`ADSC_C0_GAIN_LO]};
      conv_power_r      <= ctrl0_r[`ADSC_C0_PWR];
      // (RULE8) Enable bit or LOW_VOLTAGE_RESET
      bandgap_on_r      <= bg_en_r | lvr_enable;
    end
  end

  // Read decode
  assign rd_addr = {s_axi_araddr[4:2], 2'b00};
  always @* begin
    rd_mux = 32'h00000000;
    rd_ok  = 1'b1;
    case (rd_addr)
      `ADSC_CTRL0_ADDR: rd_mux[7:0] = {ctrl0_r[7], busy_r, ctrl0_r[5:0]};
      `ADSC_CTRL1_ADDR: rd_mux[7:0] = ctrl1_r;
      // (RULE9) Unused bits zero
      `ADSC_BGAP_ADDR:  rd_mux[7:0] = {4'h0, bg_en_r, 3'h0};
      // (RULE18) High byte by alignment
      `ADSC_RESH_ADDR:  rd_mux[7:0] = ctrl0_r[`ADSC_C0_ALIGN] ? {6'h00, result_r[9:8]}
                                                             : result_r[9:2];
      // (RULE18) Low byte by alignment
      `ADSC_RESL_ADDR:  rd_mux[7:0] = ctrl0_r[`ADSC_C0_ALIGN] ? result_r[7:0]
                                                             : {result_r[1:0], 6'h00};
      default:          rd_ok = 1'b0;
    endcase
  end

  // Read channel
  always @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      s_axi_arready <= 1'b1;
      s_axi_rvalid  <= 1'b0;
      s_axi_rdata   <= 32'h00000000;
      s_axi_rresp   <= `ADSC_RESP_OKAY;
    end else if (s_axi_arvalid && s_axi_arready) begin
      s_axi_arready <= 1'b0;
      s_axi_rvalid  <= 1'b1;
      s_axi_rdata   <= rd_mux;
      s_axi_rresp   <= (rd_ok && s_axi_araddr[31:5] == 27'h0) ? `ADSC_RESP_OKAY
                                                               : `ADSC_RESP_SLVERR;
    end else if (s_axi_rvalid && s_axi_rready) begin
      s_axi_rvalid  <= 1'b0;
      s_axi_arready <= 1'b1;
    end
  end

endmodule // adsc_top

`default_nettype wire

// ### adsc_chk.sv
// Concurrent checks on the converter control top-level ports
`timescale 1ns/10ps
`default_nettype none

module adsc_chk (
  // Clock and reset
  input wire logic       clk,
  input wire logic       sys_rst,
  // Core side
  input wire logic       lvr_enable,
  input wire logic [3:0] ext_pin_connect_r,
  input wire logic [3:0] input_route_r,
  input wire logic [2:0] ref_route_r,
  input wire logic       conv_power_r,
  input wire logic       bandgap_on_r,
  input wire logic       sample_phase_r,
  input wire logic       convert_phase_r,
  input wire logic       conv_done_r,
  input wire logic       conv_irq_flag_r
);
  default clocking @(posedge clk); endclocking
  default disable iff (sys_rst);

  logic [3:0] cc_r;  // Cycles spent in the convert phase, saturating

  // Count convert phase length
  always @(posedge clk or posedge sys_rst) begin
    if (sys_rst) cc_r <= 4'h0;
    else if (!convert_phase_r) cc_r <= 4'h0;
    else if (cc_r != 4'hF) cc_r <= cc_r + 4'h1;
  end

  AST_EXT_GUARD: assert property (ext_pin_connect_r != 4'h0 |->
    input_route_r == 4'h1 && $onehot(ext_pin_connect_r)) else $error("pin joined wrongly");
  AST_ROUTE_ONE: assert property (!$past(sys_rst) |-> $onehot(input_route_r))
    else $error("source route not one-hot");
  AST_REF_ONE: assert property (!$past(sys_rst) |-> $onehot(ref_route_r))
    else $error("reference route not one-hot");
  AST_PHASE_EXCL: assert property (!(sample_phase_r && convert_phase_r))
    else $error("phases overlap");
  AST_SAMPLE_MIN: assert property ($rose(sample_phase_r) |-> sample_phase_r[*4])
    else $error("sampling too short");
  AST_SAMPLE_NEXT: assert property ($fell(sample_phase_r) |-> convert_phase_r)
    else $error("no convert after sample");
  AST_CONV_LEN: assert property ($fell(convert_phase_r) |-> cc_r >= 4'hA)
    else $error("convert phase too short");
  AST_DONE_END: assert property ($fell(convert_phase_r) |-> ##[0:1] conv_done_r)
    else $error("no done after convert");
  AST_DONE_PULSE: assert property (conv_done_r |=> !conv_done_r)
    else $error("done longer than a cycle");
  AST_DONE_FLAG: assert property (conv_done_r |-> ##[0:1] conv_irq_flag_r)
    else $error("flag not set at done");
  AST_START_PWR: assert property ($rose(sample_phase_r) |-> conv_power_r)
    else $error("start with power off");
  AST_BGAP: assert property (lvr_enable |=> bandgap_on_r)
    else $error("bandgap off with lvr");
endmodule // adsc_chk

`default_nettype wire

// ### adsc_core_model.sv
// Behavioural analog core: a new result for each sampling start
`timescale 1ns/10ps
`default_nettype none

module adsc_core_model (
  // Clock and reset
  input  wire logic       clk,
  input  wire logic       sys_rst,
  // Phases from the control
  input  wire logic       sample_phase_r,
  input  wire logic       convert_phase_r,
  input  wire logic       conv_done_r,
  // Result
  output var  logic [9:0] core_result
);
  logic prev_r;  // Sampling phase one cycle ago

  // New value per conversion; garbage when idle
  always @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      prev_r      <= 1'b0;
      core_result <= 10'h000;
    end else begin
      prev_r <= sample_phase_r;
      if (sample_phase_r && !prev_r) core_result <= 10'($urandom);
      else if (!sample_phase_r && !convert_phase_r && !conv_done_r) core_result <= ~core_result;
    end
  end
endmodule // adsc_core_model

`default_nettype wire

// ### adsc_tb.sv
// Self-checking bench for the converter control over AXI4-Lite
`timescale 1ns/10ps
`default_nettype none

module tb;
  localparam int PWR_WAIT = 10;  // Power-up settle time in cycles
  logic        clk = 0, sys_rst = 1, low_voltage_reset = 0;
  logic [31:0] awaddr = 0, wdata = 0, araddr = 0, rdata;
  logic        awv = 0, wv = 0, bready = 0, arv = 0, rready = 0;
  logic        awr, wrd, bvalid, arr, rvalid, pwr, bg, smp, cnv, done, flag;
  logic [1:0]  bresp, rresp, gain;
  logic [3:0]  ext, inr;
  logic [2:0]  refr;
  logic [9:0]  res, exp_res;
  logic [7:0]  m0, m1, eh, el;
  int          failures = 0, checked = 0, dones = 0, cyc = 0, n, base, k;

  always #20 clk = ~clk;

  adsc_top uut (.clk(clk), .sys_rst(sys_rst), .s_axi_awaddr(awaddr), .s_axi_awvalid(awv),
    .s_axi_awready(awr), .s_axi_wdata(wdata), .s_axi_wstrb(4'hF), .s_axi_wvalid(wv),
    .s_axi_wready(wrd), .s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
    .s_axi_araddr(araddr), .s_axi_arvalid(arv), .s_axi_arready(arr), .s_axi_rdata(rdata),
    .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready), .core_result(res),
    .lvr_enable(low_voltage_reset), .ext_pin_connect_r(ext), .input_route_r(inr), .ref_route_r(refr),
    .amp_gain_sel_r(gain), .conv_power_r(pwr), .bandgap_on_r(bg), .sample_phase_r(smp),
    .convert_phase_r(cnv), .conv_done_r(done), .conv_irq_flag_r(flag));

  adsc_core_model core (.clk(clk), .sys_rst(sys_rst), .sample_phase_r(smp),
    .convert_phase_r(cnv), .conv_done_r(done), .core_result(res));

  // Conversion length and completions
  always @(posedge clk) begin
    if (smp | cnv) cyc++;
    if (done) begin
      dones++;
      exp_res = res;
    end
  end

  task chk(input logic [31:0] s, input logic [31:0] e);
    checked++;
    if (s !== e) begin
      failures++;
      $display("CHECK FAILED at %0t: seen %h expected %h", $time, s, e);
    end
  endtask

  task final_report;
    $display("checks %0d mismatches %0d", checked, failures);
    if (failures == 0 && checked > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask

  task tmo(input bit ok);
    if (!ok) begin
      failures++;
      final_report;
    end
  endtask

  task wr(input logic [4:0] a, input logic [7:0] d);
    @(posedge clk);
    awaddr <= a; wdata <= d; awv <= 1; wv <= 1; bready <= 1;
    for (n = 0; n < 200; n++) begin
      @(posedge clk);
      if (awr) awv <= 0;
      if (wrd) wv <= 0;
      if (bvalid) break;
    end
    bready <= 0;
    tmo(n < 200);
    chk(bresp, 0);
  endtask

  task rd(input logic [4:0] a, input logic [7:0] e, input logic [1:0] er);
    @(posedge clk);
    araddr <= a; arv <= 1; rready <= 1;
    for (n = 0; n < 200; n++) begin
      @(posedge clk);
      if (arr) arv <= 0;
      if (rvalid) break;
    end
    rready <= 0;
    tmo(n < 200);
    chk(rdata, e);
    chk(rresp, er);
  endtask

  initial begin
    n = $urandom(69);
    repeat (4) @(posedge clk);
    sys_rst <= 0;
    rd(0, 0, 0); rd(4, 0, 0); rd(8, 0, 0); rd(5'h14, 0, 2);
    $display("reset test done");
    for (int i = 0; i < 8; i++) begin
      n = $urandom;
      m1 = {i[1:0], n[4], i[2:1], n[7:5]};
      m0 = {4'h0, n[3], 1'(i[1:0] != 0) | n[2], n[1:0]};
      // reference code steps through 00, 01, 10, 11: pin, supply, amp, pin
      wr(0, m0 | 8'h04); wr(4, m1); wr(0, m0);
      rd(4, m1, 0);
      chk(inr, 4'h1 << m1[7:6]);
      chk(ext, (m1[7:6] == 0 && !m0[2]) ? 4'h1 << m0[1:0] : 4'h0);
      chk(refr, m1[4:3] == 1 ? 3'h2 : m1[4:3] == 2 ? 3'h4 : 3'h1);
      chk(gain, {m1[5], m0[3]});
    end
    $display("routing test done");
    for (int i = 0; i < 4; i++) begin
      wr(8, i[0] ? 8'hFF : 8'h00);
      low_voltage_reset <= i[1];
      rd(8, i[0] ? 8'h08 : 8'h00, 0);
      chk(bg, i[0] | i[1]);
    end
    low_voltage_reset <= 0;
    $display("bandgap test done");
    // codes 4-7 keep the period in range; low codes test the divider
    for (int d = 0; d < 8; d++) begin
      m0 = 8'h24 | (d[0] << 4);
      wr(4, 8'(d)); wr(0, m0);
      repeat (PWR_WAIT) @(posedge clk);
      base = dones;
      cyc = 0;
      wr(0, m0 | 8'h80); wr(0, m0);
      rd(0, m0 | 8'h40, 0);
      if (d > 0) chk(flag, 0);
      if (d > 2) begin
        wr(0, m0 | 8'h80); wr(0, m0);
      end
      for (k = 0; k < 4000 && dones == base; k++) @(posedge clk);
      tmo(dones != base);
      repeat (30) @(posedge clk);
      chk(dones - base, 1);
      chk(cyc >= (14 << d) && cyc <= (14 << d) + 1, 1);
      chk(flag, 1);
      rd(0, m0, 0);
      eh = d[0] ? {6'h0, exp_res[9:8]} : exp_res[9:2];
      el = d[0] ? exp_res[7:0] : {exp_res[1:0], 6'h0};
      rd(5'hC, eh, 0); rd(5'h10, el, 0);
    end
    $display("conversion test done");
    // power down; alignment kept at 1 as in the last conversion
    base = dones;
    wr(0, 8'hB4); wr(0, 8'h34); wr(0, 8'h14);
    for (k = 0; k < 4000 && dones == base; k++) @(posedge clk);
    tmo(dones != base);
    chk(pwr, 0);
    rd(5'hC, eh, 0); rd(5'h10, el, 0);
    base = dones;
    wr(0, 8'h94); wr(0, 8'h14);
    repeat (100) @(posedge clk);
    chk(dones - base, 0);
    rd(5'hC, eh, 0); rd(5'h10, el, 0);
    $display("power-off test done");
    final_report;
  end
endmodule // tb

bind adsc_top adsc_chk chk (.clk(clk), .sys_rst(sys_rst), .lvr_enable(lvr_enable),
  .ext_pin_connect_r(ext_pin_connect_r), .input_route_r(input_route_r),
  .ref_route_r(ref_route_r), .conv_power_r(conv_power_r), .bandgap_on_r(bandgap_on_r),
  .sample_phase_r(sample_phase_r), .convert_phase_r(convert_phase_r),
  .conv_done_r(conv_done_r), .conv_irq_flag_r(conv_irq_flag_r));

`default_nettype wire
